// ===== verilog/sacs_pkg.sv
// Shared constants and carrier types for the serial converter control sequencer.
`default_nettype none

package sacs_pkg;

  // Result and address widths.
  localparam int unsigned RES_W  = 8;
  localparam int unsigned ADDR_W = 8;

  // Conversion timing in conversion clock cycles: acquire, then three cycles per bit.
  localparam int unsigned CONV_CYCLES = 36;
  localparam int unsigned ACQ_CYCLES  = 12;
  localparam int unsigned BIT_CYCLES  = 3;

  // Select filter: a change is taken after this many stable cycles.
  localparam int unsigned CS_FILT_CYCLES = 3;

  // Rising shift clock edge that completes the address and starts a conversion.
  localparam int unsigned START_EDGE = 8;

  // Sized forms of the counts for the registers that meet them.
  localparam logic [5:0] CONV_LAST  = 6'(CONV_CYCLES - 1);
  localparam logic [5:0] ACQ_LAST   = 6'(ACQ_CYCLES - 1);
  localparam logic [1:0] BIT_LAST   = 2'(BIT_CYCLES - 1);
  localparam logic [1:0] FILT_LAST  = 2'(CS_FILT_CYCLES - 1);
  localparam logic [3:0] START_LAST = 4'(START_EDGE - 1);
  localparam logic [2:0] MSB_IDX    = 3'(RES_W - 1);

  // Values after reset.
  localparam logic [RES_W-1:0]  RESULT_RST = 8'h00;
  localparam logic [ADDR_W-1:0] CHAN_RST   = 8'h00;

  // State of the shift clock rising-edge logic: address capture and start flag.
  typedef struct packed {
    logic [3:0]        edges;
    logic [ADDR_W-1:0] addr_sr;
    logic              addr_done;
  } sacs_rise_t;

  // State of the shift clock falling-edge logic: gray-coded count of falling edges.
  typedef struct packed {
    logic [2:0] bin;
    logic [2:0] gray;
  } sacs_fall_t;

  // Converter-side outputs grouped for the analog front end.
  typedef struct packed {
    logic [RES_W-1:0]  dac_code;
    logic [ADDR_W-1:0] chan_sel;
    logic              sh_track;
  } sacs_front_t;

endpackage : sacs_pkg

`default_nettype wire

// ===== verilog/sacs_sequencer.sv
// Control sequencer of a serial 8-bit successive-approximation converter.
`default_nettype none

module sacs_sequencer (
  // Conversion clock and reset.
  input  wire logic               mclk,
  input  wire logic               rstn,
  // Host serial pins.
  input  wire logic               io_clk,
  input  wire logic               cs_n,
  input  wire logic               addr_in,
  output logic                    sdo_out,
  output logic                    sdo_oe,
  // Converter front end.
  input  wire logic               cmp_high,
  input  wire logic               auto_sh,
  output sacs_pkg::sacs_front_t   front,
  output logic                    conv_busy
);
  import sacs_pkg::*;

  // State of the conversion clock domain.
  typedef struct packed {
    logic              cs_s1;
    logic              cs_s2;
    logic              cs_filt;
    logic [1:0]        filt_cnt;
    logic              done_s1;
    logic              done_s2;
    logic              done_d;
    logic [2:0]        gray_s1;
    logic [2:0]        gray_s2;
    logic              busy;
    logic [5:0]        cyc;
    logic [1:0]        phase;
    logic [2:0]        bidx;
    logic [RES_W-1:0]  sar;
    logic [RES_W-1:0]  result;
    logic [RES_W-1:0]  shift_word;
    logic [ADDR_W-1:0] chan;
    logic              sh_track;
    logic              sdo;
    logic              oe;
  } sacs_main_t;

  sacs_main_t st;
  sacs_main_t next_st;
  sacs_rise_t rs;
  sacs_rise_t next_rs;
  sacs_fall_t fs;
  sacs_fall_t next_fs;

  logic [2:0] fall_bin;
  logic       start_req;
  logic [2:0] out_idx;

  // Shift clock rising edges: address capture, cleared by select going high.
  // Edges past the eighth are ignored, so a long frame cannot disturb the address.
  always_comb begin
    next_rs = rs;
    if (rs.edges <= START_LAST) begin
      next_rs.addr_sr = {rs.addr_sr[ADDR_W-2:0], addr_in};
      next_rs.edges   = rs.edges + 4'h1;
    end
    if (rs.edges == START_LAST) begin
      next_rs.addr_done = 1'b1;
    end
  end

  // The frame's own select ends the link-side state, so no edge after it is needed.
  // A cut frame is cleared the same way and leaves no stale count behind.
  always_ff @(posedge io_clk or posedge cs_n) begin
    if (cs_n) begin
      rs <= '0;
    end else begin
      rs <= next_rs;
    end
  end

  // Shift clock falling edges: saturating count, crossed as gray code.
  // One gray bit moves per edge, so the synchroniser never sees a torn count.
  always_comb begin
    next_fs = fs;
    if (fs.bin != MSB_IDX) begin
      next_fs.bin  = fs.bin + 3'h1;
      next_fs.gray = next_fs.bin ^ (next_fs.bin >> 1);
    end
  end

  // Falling edges advance the count; select high clears it between frames.
  always_ff @(negedge io_clk or posedge cs_n) begin
    if (cs_n) begin
      fs <= '0;
    end else begin
      fs <= next_fs;
    end
  end

  // Gray count decoded after the synchroniser.
  assign fall_bin = {st.gray_s2[2],
                     st.gray_s2[2] ^ st.gray_s2[1],
                     st.gray_s2[2] ^ st.gray_s2[1] ^ st.gray_s2[0]};
  assign out_idx  = MSB_IDX - fall_bin;

  // A start is the synchronised address-done flag rising while select is settled low.
  // An eighth edge that comes while busy or before the filter settles is dropped.
  assign start_req = st.done_s2 && !st.done_d && !st.cs_filt && !st.busy;

  // Conversion clock domain: select filter, conversion, result hold, serial output.
  always_comb begin
    next_st = st;
    // Synchronisers for pins and link-side state.
    // Two flops per crossing but the address, read raw from rs.addr_sr at start; the first stage never feeds the logic below.
    next_st.cs_s1   = cs_n;
    next_st.cs_s2   = st.cs_s1;
    next_st.done_s1 = rs.addr_done;
    next_st.done_s2 = st.done_s1;
    next_st.done_d  = st.done_s2;
    next_st.gray_s1 = fs.gray;
    next_st.gray_s2 = st.gray_s1;

    // Select change is honoured only after it has stood for three cycles.
    // A glitch shorter than the filter time clears the count and is never seen.
    if (st.cs_s2 != st.cs_filt) begin
      if (st.filt_cnt == FILT_LAST) begin
        next_st.cs_filt  = st.cs_s2;
        next_st.filt_cnt = 2'h0;
      end else begin
        next_st.filt_cnt = st.filt_cnt + 2'h1;
      end
    end else begin
      next_st.filt_cnt = 2'h0;
    end

    // Host-timed sampling tracks while select is settled low and idle.
    if (!auto_sh) begin
      next_st.sh_track = !st.cs_filt && !st.busy;
    end

    // Start: clear the trial word, latch the channel and open acquisition when auto_sh is set; host-timed tracking stops here.
    if (start_req) begin
      next_st.busy     = 1'b1;
      next_st.cyc      = 6'h00;
      next_st.phase    = 2'h0;
      next_st.bidx     = MSB_IDX;
      next_st.sar      = RESULT_RST;
      next_st.chan     = rs.addr_sr;
      next_st.sh_track = auto_sh;
    end else if (st.busy) begin
      next_st.cyc = st.cyc + 6'h01;
      if (st.cyc == ACQ_LAST) begin
        next_st.sh_track = 1'b0;
      end
      if (st.cyc > ACQ_LAST) begin
        // Each bit: set trial, let the comparator settle, keep or drop it.
        // The comparator is read on the last cycle, after two cycles to settle.
        if (st.phase == 2'h0) begin
          next_st.sar[st.bidx] = 1'b1;
        end
        if (st.phase == BIT_LAST) begin
          next_st.sar[st.bidx] = cmp_high;
          next_st.phase        = 2'h0;
          next_st.bidx         = st.bidx - 3'h1;
        end else begin
          next_st.phase = st.phase + 2'h1;
        end
      end
      // The last decision goes straight into the result as the conversion ends.
      if (st.cyc == CONV_LAST) begin
        next_st.busy   = 1'b0;
        next_st.result = {st.sar[RES_W-1:1], cmp_high};
      end
    end

    // Result snapshot is frozen while select is low.
    if (st.cs_s2) begin
      next_st.shift_word = st.result;
    end

    // Driver enabled only in the select-low period; MSB first, then per falling edge.
    // Deselected, the data pin idles at zero with its enable low.
    next_st.oe  = !st.cs_s2;
    next_st.sdo = st.cs_s2 ? 1'b0 : next_st.shift_word[out_idx];
  end

  // Conversion clock registers; select starts as if high so no false frame follows reset.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st            <= '0;
      st.cs_s1      <= 1'b1;
      st.cs_s2      <= 1'b1;
      st.cs_filt    <= 1'b1;
      st.result     <= RESULT_RST;
      st.shift_word <= RESULT_RST;
      st.chan       <= CHAN_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the registers.
  assign sdo_out        = st.sdo;
  assign sdo_oe         = st.oe;
  assign conv_busy      = st.busy;
  assign front.dac_code = st.sar;
  assign front.chan_sel = st.chan;
  assign front.sh_track = st.sh_track;

  // Checks on the conversion clock.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Conversion length and cycle counting.
  a_conv_len_start: assert property (
    $rose(st.busy) |-> ##35 st.busy ##1 !st.busy)
    else $error("conversion length is not 36 cycles");

  a_conv_cnt_bound: assert property (
    st.busy |-> st.cyc <= CONV_LAST)
    else $error("conversion counter ran past its end");

  a_busy_step: assert property (
    st.busy && st.cyc != CONV_LAST |=> st.busy && st.cyc == $past(st.cyc) + 6'h01)
    else $error("conversion counter skipped or stopped early");

  a_busy_drop: assert property (
    $fell(st.busy) |-> $past(st.cyc) == CONV_LAST)
    else $error("conversion ended before its last cycle");

  // Start of a conversion.
  a_start_latch: assert property (
    start_req |=> st.busy && st.cyc == 6'h00 && st.chan == $past(rs.addr_sr))
    else $error("conversion did not start with the latched address");

  a_start_cause: assert property (
    $rose(st.busy) |-> $past(start_req))
    else $error("conversion began without a start request");

  a_chan_hold: assert property (
    !$rose(st.busy) |-> $stable(st.chan))
    else $error("channel changed outside a conversion start");

  a_sar_clear: assert property (
    $rose(st.busy) |-> front.dac_code == RESULT_RST)
    else $error("trial word not cleared at conversion start");

  a_bidx_start: assert property (
    $rose(st.busy) |-> st.bidx == MSB_IDX && st.phase == 2'h0 && st.cyc == 6'h00)
    else $error("conversion did not begin at the top bit");

  // Successive approximation and the stored result.
  a_trial_set: assert property (
    st.busy && st.cyc > ACQ_LAST && st.phase == 2'h0 |=> st.sar[$past(st.bidx)] == 1'b1)
    else $error("trial bit not set at the start of a bit");

  a_bit_decide: assert property (
    st.busy && st.cyc > ACQ_LAST && st.phase == BIT_LAST |=>
      st.sar[$past(st.bidx)] == $past(cmp_high))
    else $error("bit decision does not follow the comparator");

  a_result_done: assert property (
    $fell(st.busy) |-> st.result == {$past(st.sar[RES_W-1:1]), $past(cmp_high)})
    else $error("result not stored at end of conversion");

  a_result_hold: assert property (
    !$fell(st.busy) |-> $stable(st.result))
    else $error("result changed outside the end of a conversion");

  a_dac_idle: assert property (
    !st.busy && !$fell(st.busy) |-> $stable(front.dac_code))
    else $error("trial word moved while no conversion runs");

  // Sample and hold.
  a_auto_track: assert property (
    $rose(st.busy) && auto_sh |-> st.sh_track ##12 !st.sh_track)
    else $error("automatic acquisition window wrong");

  a_track_start: assert property (
    $rose(st.busy) |-> front.sh_track == $past(auto_sh))
    else $error("acquisition state wrong at conversion start");

  a_track_low: assert property (
    st.busy && st.cyc > ACQ_LAST |-> front.sh_track == 1'b0)
    else $error("still tracking while bits are decided");

  a_host_track: assert property (
    !auto_sh && !st.busy && !st.cs_filt && !start_req |=> front.sh_track == 1'b1)
    else $error("host-timed tracking missing while selected and idle");

  // Select filter and serial output.
  a_filt_wait: assert property (
    (st.cs_s2 != st.cs_filt) [*3] |=> st.cs_filt == $past(st.cs_s2))
    else $error("select filter did not settle within three cycles");

  a_filt_hold: assert property (
    $changed(st.cs_filt) |-> $past(st.filt_cnt) == FILT_LAST)
    else $error("select filter changed too early");

  a_filt_rest: assert property (
    st.cs_s2 == st.cs_filt |=> st.filt_cnt == 2'h0)
    else $error("select filter count not cleared when settled");

  a_oe_select: assert property (
    st.cs_s2 |=> !sdo_oe)
    else $error("serial output driven while select high");

  a_oe_drive: assert property (
    !st.cs_s2 |=> sdo_oe)
    else $error("serial output not driven while select low");

  a_sdo_quiet: assert property (
    !sdo_oe |-> sdo_out == 1'b0)
    else $error("serial data not idle while released");

  a_msb_first: assert property (
    $rose(sdo_oe) && fall_bin == 3'h0 |-> sdo_out == st.shift_word[MSB_IDX])
    else $error("first bit out is not the MSB");

  a_bit_order: assert property (
    sdo_oe && $past(sdo_oe) |-> sdo_out == st.shift_word[$past(out_idx)])
    else $error("serial bit does not follow the falling edge count");

  a_result_keep: assert property (
    !st.cs_s2 && !$past(st.cs_s2) |-> $stable(st.shift_word))
    else $error("shift word changed inside a select-low period");

  a_word_reload: assert property (
    st.cs_s2 |=> st.shift_word == $past(st.result))
    else $error("shift word not reloaded while deselected");

endmodule : sacs_sequencer

`default_nettype wire

// ===== testbench/sacs_host_model.sv
// Host side model: drives select, shift clock and address, and reads the serial result.
`default_nettype none

module sacs_host_model (
  // Conversion clock and device data pins.
  input  wire logic mclk,
  input  wire logic sdo_out,
  input  wire logic sdo_oe,
  // Host control pins.
  output logic      io_clk,
  output logic      cs_n,
  output logic      addr_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // The shift clock stands low and select stays high between frames.
  initial begin
    io_clk  = 1'b0;
    cs_n    = 1'b1;
    addr_in = 1'b0;
  end

  // One frame with n rising shift edges; result bits are taken just before each rise.
  task automatic frame(input logic [7:0] addr, input int n, output logic [7:0] res,
                       output logic oe_ok);
    res   = 8'h00;
    @(posedge mclk);
    #1 cs_n = 1'b0;
    repeat (10) @(posedge mclk); // Select setup well past the filter time.
    #0.7 oe_ok = (sdo_oe === 1'b1);
    for (int i = 0; i < n; i++) begin
      #30 res[7-i] = (sdo_oe === 1'b1) ? sdo_out : ~sdo_out; // Released line reads inverted.
      oe_ok = oe_ok & (sdo_oe === 1'b1);
      addr_in = addr[7-i]; // Address bit set up before the rising edge.
      #10 io_clk = 1'b1;
      #40 io_clk = 1'b0;
    end
    @(posedge mclk);
    #1 cs_n = 1'b1;
    addr_in = ~addr_in;
    repeat (60) @(posedge mclk); // Select held high beyond the conversion time.
    #1 oe_ok = oe_ok & (sdo_oe === 1'b0);
  endtask : frame

endmodule : sacs_host_model

`default_nettype wire

// ===== testbench/sacs_sequencer_test.sv
// Self-checking testbench of the serial converter control sequencer.
`default_nettype none

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module sacs_sequencer_test;
  import sacs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                mclk = 1'b0;
  logic                rstn = 1'b0;
  logic                cmp_high = 1'b0;
  logic                auto_sh = 1'b1;
  wire logic           io_clk, cs_n, addr_in, sdo_out, sdo_oe, conv_busy;
  sacs_front_t         front;
  int                  err_total = 0;
  int                  tests_run = 0;
  int                  vin = 0;
  int                  busy_cnt = 0, sh_cnt = 0, busy_len = 0, sh_len = 0, convs = 0;
  logic [7:0]          chan_seen = 8'h00;

  always #2 mclk = ~mclk;

  sacs_sequencer i_sacs_sequencer (.mclk(mclk), .rstn(rstn), .io_clk(io_clk), .cs_n(cs_n),
    .addr_in(addr_in), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .cmp_high(cmp_high),
    .auto_sh(auto_sh), .front(front), .conv_busy(conv_busy));

  sacs_host_model i_sacs_host_model (.mclk(mclk), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .io_clk(io_clk), .cs_n(cs_n), .addr_in(addr_in));

  // Comparator model: the analog level against the trial word; out of range saturates.
  always @(posedge mclk) begin
    #1 cmp_high = (vin >= int'(front.dac_code));
  end

  // Measures each conversion mid-cycle, where the registered outputs have settled.
  always @(negedge mclk) begin
    if (conv_busy === 1'b1) begin
      busy_cnt++;
      if (front.sh_track === 1'b1) sh_cnt++;
      chan_seen = front.chan_sel;
    end else if (busy_cnt != 0) begin
      busy_len = busy_cnt;
      sh_len   = sh_cnt;
      busy_cnt = 0;
      sh_cnt   = 0;
      convs++;
    end
  end

  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Outputs idle after reset, data pin released.
  task automatic t_reset;
    `CHK("sdo_oe", 1'b0, sdo_oe)
    `CHK("conv_busy", 1'b0, conv_busy)
    `CHK("front", 17'h00000, front)
  endtask : t_reset

  // Full frame: reads the previous result while a new address and conversion go in.
  task automatic t_run(input logic [7:0] addr, input int v, input logic a,
                       input logic [7:0] prev);
    logic [7:0] res;
    logic       oe_ok;
    int         c0;
    c0 = convs;
    vin = v;
    auto_sh = a;
    i_sacs_host_model.frame(addr, 8, res, oe_ok);
    `CHK("result", prev, res)
    `CHK("oe_window", 1'b1, oe_ok)
    `CHK("conversions", c0 + 1, convs)
    `CHK("busy_len", CONV_CYCLES, busy_len)
    `CHK("chan_sel", addr, chan_seen)
    `CHK("acq_len", a ? ACQ_CYCLES : 0, sh_len)
  endtask : t_run

  // Frame with only five shift clocks starts no conversion.
  task automatic t_short;
    logic [7:0] res;
    logic       oe_ok;
    int         c0;
    c0 = convs;
    i_sacs_host_model.frame(8'hC3, 5, res, oe_ok);
    `CHK("short_conv", c0, convs)
  endtask : t_short

  // Hang guard.
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge mclk);
    #1 rstn = 1'b1;
    @(posedge mclk);
    #1 t_reset();
    t_run(8'h13, 'hA5, 1'b1, RESULT_RST);
    t_run(8'h07, 300, 1'b0, 8'hA5);
    t_run(8'h12, -5, 1'b1, 8'hFF);
    t_short();
    t_run(8'h0A, 'h5A, 1'b0, 8'h00);
    t_run(8'h01, 0, 1'b1, 8'h5A);
    print_verdict();
  end

endmodule : sacs_sequencer_test

`default_nettype wire
